// ===== common/clock_synth_unit_regs.vh
`ifndef CLOCK_SYNTH_UNIT_REGS_VH
`define CLOCK_SYNTH_UNIT_REGS_VH

// Field widths
`define CSU_TRIM_W      10
`define CSU_PS_W        3
`define CSU_CNT_W       13
`define CSU_NUM_W       8
`define CSU_DEN_W       16

// Reset values
`define CSU_TRIM_RST    10'h000
`define CSU_PS_RST      3'h0
`define CSU_SRC_SEL_RST 1'h0

// Reference source codes
`define CSU_SRC_RELAX   2'h0
`define CSU_SRC_XTAL    2'h1
`define CSU_SRC_EXT     2'h2

// Postscaler: divide by 2**field, field 0..5
`define CSU_PS_MAX      3'h5

// Frequency plan
`define CSU_PLL_MULT    8
`define CSU_CORE_MHZ    20
`define CSU_MAX_MHZ     32
`define CSU_TRIM_PPM    780

// Least reference period times postscale that keeps the output in range
`define CSU_MIN_PXS ((`CSU_CORE_MHZ*`CSU_PLL_MULT+`CSU_MAX_MHZ-1)/`CSU_MAX_MHZ)

// Rate generator scaling: den = period * CSU_SCALE
`define CSU_SCALE       4
`define CSU_NUM_2X_PLL  (2*`CSU_PLL_MULT*`CSU_SCALE)
`define CSU_NUM_3X_PLL  (3*`CSU_PLL_MULT*`CSU_SCALE)
`define CSU_NUM_3X_BYP  (3*`CSU_SCALE)

// Loss-of-reference timeout
`define CSU_LOSS_NS     204800
`define CSU_LOSS_CYC    ((`CSU_LOSS_NS*`CSU_CORE_MHZ)/1000)

// Lock sequencer states
`define CSU_ST_WAIT     2'h0
`define CSU_ST_MEAS     2'h1
`define CSU_ST_RUN      2'h2

`endif

// ===== core/clock_synth_unit.v
`timescale 1ns/1ps
`include "clock_synth_unit_regs.vh"

// How it works
// - Reference is relaxation oscillator, crystal, or external clock pin.
// - Bypass: double-rate output toggles on both reference edges.
// - Multiplied path: reference times eight, divided by the postscaler.
// - Postscale ratios limited to 1, 2, 4, 8, 16, 32.
// - Postscaler control is a 3-bit field.
// - System clock is double-rate clock divided by two, 50% duty.
// - Double-rate clock output feeds the system integration unit.
// - Separate triple-rate clock output feeds PWM and timers.
// - Postscale raised automatically so output never exceeds 32 MHz.
// - Reset leaves the source select cleared: relaxation oscillator.
// - Oscillator control trim field occupies bits 0 to 9.
// - Each trim step moves the relaxation oscillator about 0.078%.
// - Factory trim copied into flash option trim register after reset.
// - Loss of reference while multiplying forces safe shutdown.
// - Relaxation or crystal oscillator can be powered down.
// - Relaxation oscillator has a separate standby control.
// - Multiplier can be powered down independently.
module clock_synth_unit (
    // Clock and reset
    input  wire                   CORE_CLK,
    input  wire                   RESETN,
    input  wire                   CLK_EN,
    // Oscillator sources
    input  wire                   RELAX_OSC_IN,
    input  wire                   XTAL_OSC_IN,
    input  wire                   EXT_CLK_IN,
    // Source and multiplier control
    input  wire                   REF_SOURCE_SELECT,
    input  wire                   EXT_SOURCE_SEL,
    input  wire                   PLL_ENABLE,
    input  wire [`CSU_PS_W-1:0]   POSTSCALE,
    // Power control
    input  wire                   RELAX_POWER_DOWN,
    input  wire                   RELAX_STANDBY,
    input  wire                   XTAL_POWER_DOWN,
    input  wire                   PLL_POWER_DOWN,
    // Trim control
    input  wire                   OSC_TRIM_WR,
    input  wire [`CSU_TRIM_W-1:0] OSC_TRIM_DATA,
    input  wire [`CSU_TRIM_W-1:0] FACTORY_TRIM,
    // Status control
    input  wire                   LOSS_CLEAR,
    // Clock outputs
    output reg                    SYS2X_CLK,
    output reg                    SYS_CLK,
    output reg                    SYS3X_CLK,
    // Oscillator and trim outputs
    output reg  [`CSU_TRIM_W-1:0] OSC_TRIM,
    output reg  [`CSU_TRIM_W-1:0] FLASH_OPTION_TRIM,
    output reg                    RELAX_PD_OUT,
    output reg                    RELAX_STBY_OUT,
    output reg                    XTAL_PD_OUT,
    output reg                    PLL_PD_OUT,
    // Status
    output reg  [1:0]             SRC_ACTIVE,
    output reg                    PLL_ACTIVE,
    output reg                    PLL_LOCKED,
    output reg                    REF_LOSS,
    output reg                    SHUTDOWN_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Clamp the postscale field and raise it until the output is in range
    function [`CSU_PS_W-1:0] eff_shift;
        input [`CSU_PS_W-1:0] sel;
        input [`CSU_CNT_W-1:0] period;
        reg   [`CSU_PS_W-1:0] s;
        reg   [`CSU_CNT_W+5:0] pxs;
        integer i;
        begin
            s = (sel > `CSU_PS_MAX) ? `CSU_PS_MAX : sel;
            for (i = 0; i < 6; i = i + 1) begin
                pxs = {6'h00, period} << s;
                if (pxs < `CSU_MIN_PXS && s < `CSU_PS_MAX)
                    s = s + 3'h1;
            end
            eff_shift = s;
        end
    endfunction

    // Select one synchronised source level
    function pick_level;
        input [1:0] src;
        input [2:0] lvl;
        begin
            case (src)
                `CSU_SRC_RELAX: pick_level = lvl[0];
                `CSU_SRC_XTAL:  pick_level = lvl[1];
                `CSU_SRC_EXT:   pick_level = lvl[2];
                default:        pick_level = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [2:0]             meta_r;
    reg  [2:0]             sync_r;
    reg                    lvl_d_r;
    reg  [1:0]             state_r;
    reg  [`CSU_CNT_W-1:0]  cnt_r;
    reg  [`CSU_CNT_W-1:0]  period_r;
    reg  [1:0]             src_r;
    reg                    pll_r;
    reg  [`CSU_PS_W-1:0]   ps_r;
    reg                    ref_loss_r;
    reg                    shut_r;
    reg                    fopt_done_r;

    wire [2:0]             gated_w;
    wire [1:0]             sel_src_w;
    wire                   use_pll_w;
    wire                   cfg_chg_w;
    wire                   ref_lvl_w;
    wire                   rise_w;
    wire                   fall_w;
    wire                   loss_w;
    wire                   run_w;
    wire [`CSU_PS_W-1:0]   shift_w;
    wire [`CSU_NUM_W-1:0]  num2x_w;
    wire [`CSU_NUM_W-1:0]  num3x_w;
    wire [`CSU_DEN_W-1:0]  den_w;
    wire                   tick2x_w;
    wire                   tick3x_w;
    wire                   tog2x_w;
    wire [`CSU_CNT_W-1:0]  loss_lim_w;
    wire [31:0]            n2x_full_w;
    wire [31:0]            n3x_full_w;
    wire [31:0]            lim_full_w;

    ////////////////////////////////////////////////////////////////////////
    // Source synchronisers

    // Raw pins reach only the synchroniser; a powered-down source has no edges
    assign gated_w = sync_r & {1'b1, ~XTAL_POWER_DOWN,
                               ~RELAX_POWER_DOWN};

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end else if (CLK_EN) begin
            meta_r <= {EXT_CLK_IN, XTAL_OSC_IN, RELAX_OSC_IN};
            sync_r <= meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source and path selection

    // External selection assumes software let that source settle
    assign sel_src_w = shut_r ? `CSU_SRC_RELAX :
                       !REF_SOURCE_SELECT ? `CSU_SRC_RELAX :
                       EXT_SOURCE_SEL ? `CSU_SRC_EXT : `CSU_SRC_XTAL;
    assign use_pll_w = PLL_ENABLE & ~PLL_POWER_DOWN & ~shut_r;
    assign cfg_chg_w = (sel_src_w != src_r) || (use_pll_w != pll_r) ||
                       (POSTSCALE != ps_r);

    assign ref_lvl_w = pick_level(src_r, gated_w);
    assign rise_w    = ref_lvl_w & ~lvl_d_r;
    assign fall_w    = ~ref_lvl_w & lvl_d_r;
    assign run_w     = (state_r == `CSU_ST_RUN);

    assign lim_full_w = `CSU_LOSS_CYC - 1;
    assign loss_lim_w = lim_full_w[`CSU_CNT_W-1:0];
    assign loss_w     = !rise_w && (cnt_r == loss_lim_w);

    ////////////////////////////////////////////////////////////////////////
    // Lock sequencer: wait for an edge, measure one period, then run

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r  <= `CSU_ST_WAIT;
            cnt_r    <= {`CSU_CNT_W{1'b0}};
            period_r <= {`CSU_CNT_W{1'b0}};
            src_r    <= `CSU_SRC_RELAX;
            pll_r    <= 1'b0;
            ps_r     <= `CSU_PS_RST;
            lvl_d_r  <= 1'b1;
        end else if (CLK_EN) begin
            if (cfg_chg_w) begin
                // Hold outputs and relock on the new configuration
                src_r   <= sel_src_w;
                pll_r   <= use_pll_w;
                ps_r    <= POSTSCALE;
                state_r <= `CSU_ST_WAIT;
                cnt_r   <= {`CSU_CNT_W{1'b0}};
                lvl_d_r <= 1'b1;
            end else begin
                lvl_d_r <= ref_lvl_w;
                if (loss_w) begin
                    state_r <= `CSU_ST_WAIT;
                    cnt_r   <= {`CSU_CNT_W{1'b0}};
                end else begin
                    case (state_r)
                        `CSU_ST_WAIT: begin
                            if (rise_w) begin
                                state_r <= `CSU_ST_MEAS;
                                cnt_r   <= {`CSU_CNT_W{1'b0}};
                            end else begin
                                cnt_r   <= cnt_r + 1'b1;
                            end
                        end
                        `CSU_ST_MEAS, `CSU_ST_RUN: begin
                            if (rise_w) begin
                                period_r <= cnt_r + 1'b1;
                                cnt_r    <= {`CSU_CNT_W{1'b0}};
                                state_r  <= `CSU_ST_RUN;
                            end else begin
                                cnt_r    <= cnt_r + 1'b1;
                            end
                        end
                        default: begin
                            state_r <= `CSU_ST_WAIT;
                            cnt_r   <= {`CSU_CNT_W{1'b0}};
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loss detection and safety shutdown

    // A loss in the clearing cycle keeps the flag set
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ref_loss_r <= 1'b0;
            shut_r     <= 1'b0;
        end else if (CLK_EN) begin
            if (loss_w && !cfg_chg_w) begin
                ref_loss_r <= 1'b1;
                if (pll_r)
                    shut_r <= 1'b1;
            end else if (LOSS_CLEAR) begin
                ref_loss_r <= 1'b0;
                shut_r     <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate generators

    assign shift_w = eff_shift(ps_r, period_r);
    assign n2x_full_w = `CSU_NUM_2X_PLL >> shift_w;
    assign n3x_full_w = pll_r ? (`CSU_NUM_3X_PLL >> shift_w)
                              : `CSU_NUM_3X_BYP;
    assign num2x_w = n2x_full_w[`CSU_NUM_W-1:0];
    assign num3x_w = n3x_full_w[`CSU_NUM_W-1:0];
    assign den_w   = {1'b0, period_r, 2'b00};

    rate_tick_gen gen2x (
        .clk  (CORE_CLK),
        .rstn (RESETN),
        .ce   (CLK_EN),
        .clr  (!run_w || cfg_chg_w || !pll_r),
        .num  (num2x_w),
        .den  (den_w),
        .tick (tick2x_w)
    );

    rate_tick_gen gen3x (
        .clk  (CORE_CLK),
        .rstn (RESETN),
        .ce   (CLK_EN),
        .clr  (!run_w || cfg_chg_w),
        .num  (num3x_w),
        .den  (den_w),
        .tick (tick3x_w)
    );

    // Bypass follows both reference edges so 2X equals the reference
    assign tog2x_w = run_w && !cfg_chg_w &&
                     (pll_r ? tick2x_w : (rise_w | fall_w));

    ////////////////////////////////////////////////////////////////////////
    // Clock outputs

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SYS2X_CLK <= 1'b0;
            SYS_CLK   <= 1'b0;
            SYS3X_CLK <= 1'b0;
        end else if (CLK_EN) begin
            if (tog2x_w) begin
                SYS2X_CLK <= ~SYS2X_CLK;
                if (!SYS2X_CLK)
                    SYS_CLK <= ~SYS_CLK;
            end
            if (run_w && !cfg_chg_w && tick3x_w)
                SYS3X_CLK <= ~SYS3X_CLK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim and flash option registers

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            OSC_TRIM          <= `CSU_TRIM_RST;
            FLASH_OPTION_TRIM <= `CSU_TRIM_RST;
            fopt_done_r       <= 1'b0;
        end else if (CLK_EN) begin
            if (!fopt_done_r) begin
                FLASH_OPTION_TRIM <= FACTORY_TRIM;
                fopt_done_r       <= 1'b1;
            end
            // Boot code writes the factory value here
            if (OSC_TRIM_WR)
                OSC_TRIM <= OSC_TRIM_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and status outputs

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RELAX_PD_OUT    <= 1'b0;
            RELAX_STBY_OUT  <= 1'b0;
            XTAL_PD_OUT     <= 1'b0;
            PLL_PD_OUT      <= 1'b0;
            SRC_ACTIVE      <= `CSU_SRC_RELAX;
            PLL_ACTIVE      <= 1'b0;
            PLL_LOCKED      <= 1'b0;
            REF_LOSS        <= 1'b0;
            SHUTDOWN_ACTIVE <= 1'b0;
        end else if (CLK_EN) begin
            // Shutdown keeps the relaxation oscillator alive
            RELAX_PD_OUT    <= RELAX_POWER_DOWN & ~shut_r;
            RELAX_STBY_OUT  <= RELAX_STANDBY & ~RELAX_POWER_DOWN;
            XTAL_PD_OUT     <= XTAL_POWER_DOWN;
            PLL_PD_OUT      <= PLL_POWER_DOWN;
            SRC_ACTIVE      <= src_r;
            PLL_ACTIVE      <= pll_r;
            PLL_LOCKED      <= pll_r && run_w;
            REF_LOSS        <= ref_loss_r;
            SHUTDOWN_ACTIVE <= shut_r;
        end
    end

endmodule

// ===== core/rate_tick_gen.v
`timescale 1ns/1ps
`include "clock_synth_unit_regs.vh"

module rate_tick_gen (
    // Clock and reset
    input  wire                    clk,
    input  wire                    rstn,
    input  wire                    ce,
    // Control
    input  wire                    clr,
    input  wire [`CSU_NUM_W-1:0]   num,
    input  wire [`CSU_DEN_W-1:0]   den,
    // Result
    output reg                     tick
);

    reg  [`CSU_DEN_W-1:0] acc_r;
    wire [`CSU_DEN_W:0]   sum_w;
    wire [`CSU_DEN_W:0]   rem_w;

    assign sum_w = {1'b0, acc_r} + {{(`CSU_DEN_W+1-`CSU_NUM_W){1'b0}}, num};
    assign rem_w = sum_w - {1'b0, den};

    // Emits num/den ticks per core cycle; rates above one tick a cycle saturate
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_r <= {`CSU_DEN_W{1'b0}};
            tick  <= 1'b0;
        end else if (ce) begin
            if (clr || den == {`CSU_DEN_W{1'b0}}) begin
                acc_r <= {`CSU_DEN_W{1'b0}};
                tick  <= 1'b0;
            end else if (sum_w >= {1'b0, den}) begin
                tick  <= 1'b1;
                if (rem_w < {1'b0, den})
                    acc_r <= rem_w[`CSU_DEN_W-1:0];
                else
                    acc_r <= {`CSU_DEN_W{1'b0}};
            end else begin
                tick  <= 1'b0;
                acc_r <= sum_w[`CSU_DEN_W-1:0];
            end
        end
    end

endmodule

// ===== verif/clock_synth_unit_assertions.sv
`timescale 1ns/1ps
`include "clock_synth_unit_regs.vh"
module clock_synth_unit_assertions (
    // Clock and controls
    input wire logic                   CORE_CLK,
    input wire logic                   RESETN,
    input wire logic                   CLK_EN,
    input wire logic                   RELAX_POWER_DOWN,
    input wire logic                   RELAX_STANDBY,
    input wire logic                   XTAL_POWER_DOWN,
    input wire logic                   PLL_POWER_DOWN,
    input wire logic                   OSC_TRIM_WR,
    input wire logic [`CSU_TRIM_W-1:0] OSC_TRIM_DATA,
    input wire logic [`CSU_TRIM_W-1:0] FACTORY_TRIM,
    input wire logic                   LOSS_CLEAR,
    // Outputs
    input wire logic                   SYS2X_CLK,
    input wire logic                   SYS_CLK,
    input wire logic [`CSU_TRIM_W-1:0] OSC_TRIM,
    input wire logic [`CSU_TRIM_W-1:0] FLASH_OPTION_TRIM,
    input wire logic                   RELAX_PD_OUT,
    input wire logic                   RELAX_STBY_OUT,
    input wire logic                   XTAL_PD_OUT,
    input wire logic                   PLL_PD_OUT,
    input wire logic [1:0]             SRC_ACTIVE,
    input wire logic                   PLL_ACTIVE,
    input wire logic                   REF_LOSS,
    input wire logic                   SHUTDOWN_ACTIVE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    // Counts the first edges after reset
    logic [1:0] up_r;
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_trim_wr;
        OSC_TRIM_WR && CLK_EN |=> OSC_TRIM == $past(OSC_TRIM_DATA);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim lost");
    property p_trim_hold;
        !OSC_TRIM_WR || !CLK_EN |=> $stable(OSC_TRIM);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim moved");
    property p_flash;
        up_r == 2'h3 |-> FLASH_OPTION_TRIM == FACTORY_TRIM;
    endproperty
    a_flash: assert property (p_flash) else $error("factory copy");
    property p_relax_pd;
        $past(CLK_EN) && !SHUTDOWN_ACTIVE && !$past(SHUTDOWN_ACTIVE)
            |-> RELAX_PD_OUT == $past(RELAX_POWER_DOWN);
    endproperty
    a_relax_pd: assert property (p_relax_pd) else $error("relax pd");
    property p_stby;
        $past(CLK_EN) |-> RELAX_STBY_OUT ==
            ($past(RELAX_STANDBY) && !$past(RELAX_POWER_DOWN));
    endproperty
    a_stby: assert property (p_stby) else $error("standby flag");
    property p_pd_pins;
        $past(CLK_EN) |-> XTAL_PD_OUT == $past(XTAL_POWER_DOWN)
            && PLL_PD_OUT == $past(PLL_POWER_DOWN);
    endproperty
    a_pd_pins: assert property (p_pd_pins) else $error("pd pins");
    property p_sys_div;
        $rose(SYS2X_CLK) && CLK_EN |-> ##[0:1] $changed(SYS_CLK);
    endproperty
    a_sys_div: assert property (p_sys_div) else $error("sys div");
    property p_shut_src;
        $rose(SHUTDOWN_ACTIVE) |-> ##[0:4]
            (SRC_ACTIVE == `CSU_SRC_RELAX && !PLL_ACTIVE);
    endproperty
    a_shut_src: assert property (p_shut_src) else $error("shutdown");
    property p_loss_sticky;
        REF_LOSS && !LOSS_CLEAR && !$past(LOSS_CLEAR) |=> REF_LOSS;
    endproperty
    a_loss_sticky: assert property (p_loss_sticky) else $error("loss");
endmodule
bind clock_synth_unit clock_synth_unit_assertions u_chk (.*);

// ===== verif/clock_synth_unit_tb_top.sv
`timescale 1ns/1ps
`include "clock_synth_unit_regs.vh"
module clock_synth_unit_tb_top;
    localparam int W = 1400;
    logic       core_clk = 1'b0;
    logic       resetn, clk_en, ref_sel, ext_sel, pll_en, halt;
    logic       relax_pd, relax_stby, xtal_pd, pll_pd, trim_wr, loss_clr;
    logic [2:0] postscale;
    logic [9:0] trim_data, factory_trim;
    wire        relax_osc, xtal_osc, ext_clk, s2x, s1x, s3x;
    wire  [9:0] osc_trim, flash_trim;
    wire        relax_pd_o, stby_o, xtal_pd_o, pll_pd_o;
    wire  [1:0] src_act;
    wire        pll_act, pll_lock, ref_loss, shut;
    int         err_count = 0, cmp_count = 0, cyc = 0;

    clock_synth_unit dut (
        .CORE_CLK(core_clk), .RESETN(resetn), .CLK_EN(clk_en),
        .RELAX_OSC_IN(relax_osc), .XTAL_OSC_IN(xtal_osc),
        .EXT_CLK_IN(ext_clk), .REF_SOURCE_SELECT(ref_sel),
        .EXT_SOURCE_SEL(ext_sel), .PLL_ENABLE(pll_en), .POSTSCALE(postscale),
        .RELAX_POWER_DOWN(relax_pd), .RELAX_STANDBY(relax_stby),
        .XTAL_POWER_DOWN(xtal_pd), .PLL_POWER_DOWN(pll_pd),
        .OSC_TRIM_WR(trim_wr), .OSC_TRIM_DATA(trim_data),
        .FACTORY_TRIM(factory_trim), .LOSS_CLEAR(loss_clr),
        .SYS2X_CLK(s2x), .SYS_CLK(s1x), .SYS3X_CLK(s3x),
        .OSC_TRIM(osc_trim), .FLASH_OPTION_TRIM(flash_trim),
        .RELAX_PD_OUT(relax_pd_o), .RELAX_STBY_OUT(stby_o),
        .XTAL_PD_OUT(xtal_pd_o), .PLL_PD_OUT(pll_pd_o),
        .SRC_ACTIVE(src_act), .PLL_ACTIVE(pll_act), .PLL_LOCKED(pll_lock),
        .REF_LOSS(ref_loss), .SHUTDOWN_ACTIVE(shut));
    osc_source_model u_osc (
        .relax_pd(relax_pd_o), .xtal_pd(xtal_pd_o), .halt(halt),
        .relax_osc(relax_osc), .xtal_osc(xtal_osc), .ext_clk(ext_clk));

    always #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, exp, input int tol);
        cmp_count++;
        if ($isunknown(got) || (tol == 0 ? got !== exp :
            (got > exp + tol || got + tol < exp))) begin
            err_count++;
            $display("Error at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Double-rate toggles expected in W core cycles
    function automatic int exp2x(input logic pll, input int n, per);
        int k;
        k = (n > 5) ? 5 : n;
        while ((per << k) < 5 && k < 5) k++;
        return pll ? W * 16 / (per << k) : 2 * W / per;
    endfunction
    task automatic settle;
        repeat (450) @(negedge core_clk);
    endtask
    task automatic measure(input int per, input logic pll, input int n);
        int c2, c1, c3, e;
        logic p2, p1, p3;
        {c2, c1, c3} = '0;
        {p2, p1, p3} = {s2x, s1x, s3x};
        repeat (W) begin
            @(negedge core_clk);
            c2 += (s2x !== p2);
            c1 += (s1x !== p1);
            c3 += (s3x !== p3);
            {p2, p1, p3} = {s2x, s1x, s3x};
        end
        e = exp2x(pll, n, per);
        check(c2, e, 3);
        check(c1, e / 2, 2);
        check(c3, e * 3 / 2, 4);
        check(pll_act, pll, 0);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 40000) begin
            err_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [9:0] d;
        int w;
        void'($urandom(58501));
        factory_trim = 10'($urandom);
        {resetn, ref_sel, ext_sel, pll_en, relax_pd, relax_stby} = '0;
        {xtal_pd, pll_pd, trim_wr, loss_clr, halt, postscale} = '0;
        trim_data = 10'h000;
        clk_en = 1'b1;
        repeat (2) @(negedge core_clk);
        check(src_act, `CSU_SRC_RELAX, 0);
        resetn = 1'b1;
        repeat (3) @(negedge core_clk);
        check(flash_trim, factory_trim, 0);
        check(osc_trim, `CSU_TRIM_RST, 0);
        for (int i = 0; i < 4; i++) begin
            d = 10'($urandom);
            trim_data = d;
            trim_wr = 1'b1;
            @(negedge core_clk);
            check(osc_trim, d, 0);
        end
        // A frozen clock must not take the strobe
        clk_en = 1'b0;
        trim_data = ~d;
        @(negedge core_clk);
        {clk_en, trim_wr} = 2'b10;
        check(osc_trim, d, 0);
        trim_data = flash_trim;
        trim_wr = 1'b1;
        @(negedge core_clk);
        trim_wr = 1'b0;
        check(osc_trim, factory_trim, 0);
        settle();
        measure(100, 1'b0, 0);
        pll_en = 1'b1;
        for (int n = 0; n < 8; n++) begin
            postscale = 3'(n);
            settle();
            check(pll_lock, 1'b1, 0);
            measure(100, 1'b1, n);
        end
        // Crystal has run since time zero, so it is stable
        {ref_sel, ext_sel, pll_en} = 3'b100;
        settle();
        check(src_act, `CSU_SRC_XTAL, 0);
        measure(70, 1'b0, 0);
        {ref_sel, ext_sel, pll_en, postscale} = 6'b111011;
        for (int i = 0; i < 450; i++) begin
            {relax_stby, relax_pd, xtal_pd} = 3'($urandom);
            @(negedge core_clk);
        end
        {relax_stby, relax_pd, xtal_pd} = 3'b000;
        check(src_act, `CSU_SRC_EXT, 0);
        measure(120, 1'b1, 3);
        pll_pd = 1'b1;
        settle();
        measure(120, 1'b0, 0);
        pll_pd = 1'b0;
        settle();
        // Reference stops while multiplying
        halt = 1'b1;
        w = 0;
        while (ref_loss !== 1'b1 && w < 4400) begin
            @(negedge core_clk);
            w++;
        end
        check(w, 4040, 64);
        check(shut, 1'b1, 0);
        repeat (5) @(negedge core_clk);
        check({src_act, pll_act}, 3'h0, 0);
        {halt, ref_sel} = 2'b00;
        repeat (300) @(negedge core_clk);
        loss_clr = 1'b1;
        @(negedge core_clk);
        loss_clr = 1'b0;
        repeat (3) @(negedge core_clk);
        check({ref_loss, shut}, 2'h0, 0);
        finish_test();
    end
endmodule

// ===== verif/osc_source_model.sv
`timescale 1ns/1ps
module osc_source_model #(
    parameter int RELAX_HALF_NS = 2500,
    parameter int XTAL_HALF_NS  = 1750,
    parameter int EXT_HALF_NS   = 3000
) (
    // Power and fault control
    input  wire logic relax_pd,
    input  wire logic xtal_pd,
    input  wire logic halt,
    // Oscillator levels
    output logic      relax_osc,
    output logic      xtal_osc,
    output logic      ext_clk
);
    initial begin
        {relax_osc, xtal_osc, ext_clk} = 3'h0;
    end
    // A powered-down or halted source holds its level
    always begin
        #(RELAX_HALF_NS);
        if (!relax_pd && !halt) relax_osc = ~relax_osc;
    end
    always begin
        #(XTAL_HALF_NS);
        if (!xtal_pd && !halt) xtal_osc = ~xtal_osc;
    end
    always begin
        #(EXT_HALF_NS);
        if (!halt) ext_clk = ~ext_clk;
    end
endmodule
